// ---- src/tccu_defs.svh ----
`ifndef TCCU_DEFS_SVH
`define TCCU_DEFS_SVH

// Register byte offsets
`define TCCU_OFS_EDGE    8'h00
`define TCCU_OFS_OPTION  8'h04
`define TCCU_OFS_CH0_COMPARE_BUFFER    8'h08
`define TCCU_OFS_CCR1    8'h0C
`define TCCU_OFS_CTRL    8'h10
`define TCCU_OFS_COUNT   8'h14

// Reset values
`define TCCU_RST_BYTE    8'h00
`define TCCU_RST_CCR     16'h0000
`define TCCU_RST_CTRL    10'h000

// Option register fields
`define TCCU_OPT_OVF     0
`define TCCU_OPT_ROLE0   4
`define TCCU_OPT_ROLE1   5

// Timer mode codes
`define TCCU_MD_INTERVAL 3'h0
`define TCCU_MD_EVENT    3'h1
`define TCCU_MD_TRIGGER  3'h2
`define TCCU_MD_ONESHOT  3'h3
`define TCCU_MD_PWM      3'h4
`define TCCU_MD_FREE     3'h5
`define TCCU_MD_WIDTH    3'h6

// Counter limits
`define TCCU_CNT_MAX     16'hFFFF
`define TCCU_CNT_ZERO    16'h0000

// Bus responses
`define TCCU_RESP_OKAY   2'h0
`define TCCU_RESP_SLVERR 2'h2

`endif

// ---- src/tccu_pkg.sv ----
package tccu_pkg;

  typedef struct packed {
    logic [1:0] trigEdge;
    logic [1:0] eventEdge;
  } tccu_edge_sel_type;

  typedef struct packed {
    logic [1:0] capEdge1;
    logic [1:0] capEdge0;
    logic       outEn0;
    logic [2:0] mode;
    logic       extEventClkSel;
    logic       countEnable;
  } tccu_ctrl_type;

endpackage

// ---- src/tccu_top.sv ----
// Behaviour
// R1: Event edge field 00 off, 01 rising, 10 falling, 11 both edges.
// R2: Trigger edge field decodes the same way on the shared input.
// R3: Software changes edge fields only while counting is disabled.
// R4: Event edges count only with external clock select or mode 001.
// R5: Trigger edges act only in modes 010 and 011.
// R6: Channel 1 role bit: 0 compare, 1 capture, free-running only.
// R7: Channel 0 role bit: 0 compare, 1 capture, free-running only.
// R8: Overflow flag sets on FFFFH to 0000H wrap in free-run or width mode.
// R9: Overflow request pulses with the flag set, only in those modes.
// R10: Overflow flag clears on software write of 0 or count disable.
// R11: Reads keep the flag; writing 1 does nothing.
// R12: Software changes role bits only while counting is disabled.
// R13: Software writes zero to option bits 1 to 3, 6 and 7.
// R14: Channel 0 role: bit in free-run, capture in width, else compare.
// R15: Channel 1 follows the same role scheme with its own bit.
// R16: Both channel registers are 16-bit, whole-word, reset 0000H.
// R17: Channel 0 writes load a compare buffer; match raises request.
// R18: Enabled channel 0 output toggles on every compare match.
// R19: In cycle modes a channel 0 match clears the counter.
// R20: Free-run capture stores the counter on a valid input edge.
// R21: Width mode capture stores the counter and clears it.
// R22: Reads colliding with capture return a consistent value.
// R23: Input pins are synchronised before edge detection.
`timescale 1ns/1ps
`include "tccu_defs.svh"

module tccu_top
  import tccu_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              clkEn,
  input  wire logic              countTick,
  input  wire logic              ch0SharedInput,
  input  wire logic              ch1CaptureInput,
  output logic                   ch0TimerOutput,
  output logic                   overflowIrq,
  output logic                   ch0MatchIrq,
  output logic                   ch1MatchIrq,
  output logic                   triggerValid,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  function automatic logic edgeHit(input logic [1:0] sel,
                                   input logic rise,
                                   input logic fall);
    edgeHit = (sel[0] & rise) | (sel[1] & fall);
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == ADDR_W'(`TCCU_OFS_EDGE))
             | (a == ADDR_W'(`TCCU_OFS_OPTION))
             | (a == ADDR_W'(`TCCU_OFS_CH0_COMPARE_BUFFER))
             | (a == ADDR_W'(`TCCU_OFS_CCR1))
             | (a == ADDR_W'(`TCCU_OFS_CTRL))
             | (a == ADDR_W'(`TCCU_OFS_COUNT));
  endfunction

  tccu_edge_sel_type edgeSel_q, edgeSel_d;
  tccu_ctrl_type     ctrl_q, ctrl_d;
  logic [15:0]       ch0_compare_buffer_q, ch0_compare_buffer_d, ccr1_q, ccr1_d;
  logic [15:0]       buf0_q, buf0_d, buf1_q, buf1_d;
  logic [15:0]       cnt_q, cnt_d;
  logic              role0_q, role1_q, ovf_q, ovf_d;
  logic              ceDly_q, out0_q, out0_d;
  logic [2:0]        sync0_q, sync1_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0]       wData_q;
  logic [3:0]        wStrb_q;
  logic              ovfIrq_q, m0Irq_q, m1Irq_q, trigV_q;
  logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q;

  // Bus decode
  wire doWrite   = ~awready_q & ~wready_q & ~bvalid_q;
  wire lowLane   = wStrb_q[0];
  wire fullHalf  = &wStrb_q[1:0];
  wire wrEdge    = doWrite & lowLane
                 & (awAddr_q == ADDR_W'(`TCCU_OFS_EDGE));
  wire wrOption  = doWrite & lowLane
                 & (awAddr_q == ADDR_W'(`TCCU_OFS_OPTION));
  wire wrCcr0    = doWrite & fullHalf
                 & (awAddr_q == ADDR_W'(`TCCU_OFS_CH0_COMPARE_BUFFER)); // R16
  wire wrCcr1    = doWrite & fullHalf
                 & (awAddr_q == ADDR_W'(`TCCU_OFS_CCR1)); // R16
  wire wrCtrl    = doWrite & lowLane & wStrb_q[1]
                 & (awAddr_q == ADDR_W'(`TCCU_OFS_CTRL));
  wire readTaken = s_axi_arvalid & arready_q;

  // Pin edges on the synchronised copies only
  wire rise0 = sync0_q[1] & ~sync0_q[2]; // R23
  wire fall0 = ~sync0_q[1] & sync0_q[2]; // R23
  wire rise1 = sync1_q[1] & ~sync1_q[2]; // R23
  wire fall1 = ~sync1_q[1] & sync1_q[2]; // R23

  // Mode decode
  wire [2:0] md      = ctrl_q.mode;
  wire ce            = ctrl_q.countEnable;
  wire modeFree      = md == `TCCU_MD_FREE;
  wire modeWidth     = md == `TCCU_MD_WIDTH;
  wire modeTrig      = (md == `TCCU_MD_TRIGGER) | (md == `TCCU_MD_ONESHOT);
  wire clearMode     = md <= `TCCU_MD_PWM;
  wire batchMode     = (md == `TCCU_MD_TRIGGER) | (md == `TCCU_MD_PWM);
  wire useEvent      = ctrl_q.extEventClkSel
                     | (md == `TCCU_MD_EVENT); // R4
  wire eventHit      = useEvent
                     & edgeHit(edgeSel_q.eventEdge, rise0, fall0); // R1
  wire trigHit       = ce & modeTrig
                     & edgeHit(edgeSel_q.trigEdge, rise0, fall0); // R2 R5
  wire capRole0      = (modeFree & role0_q) | modeWidth; // R7 R14
  wire capRole1      = (modeFree & role1_q) | modeWidth; // R6 R15
  wire cap0          = ce & capRole0
                     & edgeHit(ctrl_q.capEdge0, rise0, fall0); // R20
  wire cap1          = ce & capRole1
                     & edgeHit(ctrl_q.capEdge1, rise1, fall1); // R20
  wire startPulse    = ce & ~ceDly_q;
  wire tick          = useEvent ? eventHit : countTick;
  wire running       = ce & ~startPulse;
  wire match0        = running & tick & ~capRole0
                     & (cnt_q == buf0_q); // R17
  wire match1        = running & tick & ~capRole1
                     & (cnt_q == buf1_q);
  wire widthClear    = modeWidth & (cap0 | cap1); // R21
  wire matchClear    = match0 & clearMode; // R19
  wire restart       = trigHit | widthClear;
  wire incr          = running & tick & ~restart & ~matchClear;
  wire ovfSet        = incr & (cnt_q == `TCCU_CNT_MAX)
                     & (modeFree | modeWidth); // R8
  wire ovfWriteZero  = wrOption & ~wData_q[`TCCU_OPT_OVF]; // R11
  // Counter core kept minimal: tick source, clears and wrap
  always_comb
  begin
    if (!ce)
      cnt_d = `TCCU_CNT_MAX;
    else if (startPulse | restart | matchClear)
      cnt_d = `TCCU_CNT_ZERO; // R19 R21
    else if (incr)
      cnt_d = cnt_q + 16'h0001;
    else
      cnt_d = cnt_q;
  end

  // Set wins over the software clear
  assign ovf_d = ovfSet | (ovf_q & ce & ~ovfWriteZero); // R10 R11
  assign edgeSel_d = wrEdge ? tccu_edge_sel_type'(wData_q[3:0]) : edgeSel_q;
  assign ctrl_d    = wrCtrl ? tccu_ctrl_type'(wData_q[9:0]) : ctrl_q;
  // Capture takes priority over a colliding software write
  assign ch0_compare_buffer_d = cap0 ? cnt_q : (wrCcr0 ? wData_q[15:0] : ch0_compare_buffer_q); // R20
  assign ccr1_d = cap1 ? cnt_q : (wrCcr1 ? wData_q[15:0] : ccr1_q); // R20
  // Anytime modes load the buffer on write, batch modes at cycle end
  assign buf0_d = (startPulse | (wrCcr0 & ~batchMode)
                  | (match0 & batchMode)) ? ch0_compare_buffer_d : buf0_q; // R17
  assign buf1_d = (startPulse | (wrCcr1 & ~batchMode)
                  | (match0 & batchMode)) ? ccr1_d : buf1_q;
  assign out0_d = ~ctrl_q.outEn0 ? 1'b0
                : ((startPulse | match0) ? ~out0_q : out0_q); // R18

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync0_q <= 3'h0;
      sync1_q <= 3'h0;
    end
    else if (clkEn)
    begin
      sync0_q <= {sync0_q[1:0], ch0SharedInput}; // R23
      sync1_q <= {sync1_q[1:0], ch1CaptureInput}; // R23
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      edgeSel_q <= tccu_edge_sel_type'(4'h0);
      ctrl_q    <= tccu_ctrl_type'(`TCCU_RST_CTRL);
      role0_q   <= 1'b0;
      role1_q   <= 1'b0;
      ovf_q     <= 1'b0;
    end
    else if (clkEn)
    begin
      edgeSel_q <= edgeSel_d;
      ctrl_q    <= ctrl_d;
      ovf_q     <= ovf_d;
      if (wrOption)
      begin
        role0_q <= wData_q[`TCCU_OPT_ROLE0]; // R7
        role1_q <= wData_q[`TCCU_OPT_ROLE1]; // R6
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ch0_compare_buffer_q  <= `TCCU_RST_CCR; // R16
      ccr1_q  <= `TCCU_RST_CCR; // R16
      buf0_q  <= `TCCU_RST_CCR;
      buf1_q  <= `TCCU_RST_CCR;
      cnt_q   <= `TCCU_CNT_MAX;
      ceDly_q <= 1'b0;
      out0_q  <= 1'b0;
    end
    else if (clkEn)
    begin
      ch0_compare_buffer_q  <= ch0_compare_buffer_d;
      ccr1_q  <= ccr1_d;
      buf0_q  <= buf0_d;
      buf1_q  <= buf1_d;
      cnt_q   <= cnt_d;
      ceDly_q <= ce;
      out0_q  <= out0_d;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ovfIrq_q <= 1'b0;
      m0Irq_q  <= 1'b0;
      m1Irq_q  <= 1'b0;
      trigV_q  <= 1'b0;
    end
    else if (clkEn)
    begin
      ovfIrq_q <= ovfSet; // R9
      m0Irq_q  <= match0; // R17
      m1Irq_q  <= match1;
      trigV_q  <= trigHit; // R5
    end
  end

  // Read mux; channel registers are latched whole in one edge
  logic [31:0] readMux;
  always_comb
  begin
    readMux = 32'h0000_0000;
    case (s_axi_araddr)
      ADDR_W'(`TCCU_OFS_EDGE):   readMux[3:0] = edgeSel_q;
      ADDR_W'(`TCCU_OFS_OPTION):
      begin
        readMux[`TCCU_OPT_OVF]   = ovf_q; // R11
        readMux[`TCCU_OPT_ROLE0] = role0_q;
        readMux[`TCCU_OPT_ROLE1] = role1_q;
      end
      ADDR_W'(`TCCU_OFS_CH0_COMPARE_BUFFER):   readMux[15:0] = ch0_compare_buffer_q; // R22
      ADDR_W'(`TCCU_OFS_CCR1):   readMux[15:0] = ccr1_q; // R22
      ADDR_W'(`TCCU_OFS_CTRL):   readMux[9:0] = ctrl_q;
      ADDR_W'(`TCCU_OFS_COUNT):  readMux[15:0] = ce ? cnt_q : `TCCU_CNT_ZERO;
      default:                   readMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `TCCU_RESP_OKAY;
      awAddr_q  <= '0;
      wData_q   <= 32'h0000_0000;
      wStrb_q   <= 4'h0;
    end
    else if (clkEn)
    begin
      if (s_axi_awvalid & awready_q)
      begin
        awAddr_q  <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid & wready_q)
      begin
        wData_q  <= s_axi_wdata;
        wStrb_q  <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (doWrite)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= isMapped(awAddr_q) ? `TCCU_RESP_OKAY
                                       : `TCCU_RESP_SLVERR;
      end
      if (bvalid_q & s_axi_bready)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `TCCU_RESP_OKAY;
    end
    else if (clkEn)
    begin
      if (readTaken)
      begin
        rdata_q   <= readMux;
        rresp_q   <= isMapped(s_axi_araddr) ? `TCCU_RESP_OKAY
                                            : `TCCU_RESP_SLVERR;
        rvalid_q  <= 1'b1;
        arready_q <= 1'b0;
      end
      else if (rvalid_q & s_axi_rready)
      begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign ch0TimerOutput = out0_q;
  assign overflowIrq    = ovfIrq_q;
  assign ch0MatchIrq    = m0Irq_q;
  assign ch1MatchIrq    = m1Irq_q;
  assign triggerValid   = trigV_q;
  assign s_axi_awready  = awready_q;
  assign s_axi_wready   = wready_q;
  assign s_axi_bvalid   = bvalid_q;
  assign s_axi_bresp    = bresp_q;
  assign s_axi_arready  = arready_q;
  assign s_axi_rvalid   = rvalid_q;
  assign s_axi_rdata    = rdata_q;
  assign s_axi_rresp    = rresp_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_ovf_needs_mode: assert property ( // R8
    clkEn && $rose(ovf_q) |-> $past(modeFree || modeWidth))
    else $error("overflow flag set outside its modes");
  a_ovf_irq_same: assert property ( // R9
    clkEn && $rose(ovf_q) |-> overflowIrq)
    else $error("overflow request not with flag set");
  a_ovf_clear_ce: assert property ( // R10
    clkEn && $past(clkEn) && !$past(ce) |-> !ovf_q)
    else $error("overflow flag held while count disabled");
  a_ovf_write_one: assert property ( // R11
    clkEn && wrOption && wData_q[`TCCU_OPT_OVF] && !ovf_q && !ovfSet
    |=> !ovf_q)
    else $error("software write of one set the flag");
  a_width_capture: assert property ( // R21
    clkEn && cap0 && modeWidth |=> ch0_compare_buffer_q == $past(cnt_q)
                                   && cnt_q == `TCCU_CNT_ZERO)
    else $error("width capture did not store and clear");
  a_match_clear: assert property ( // R19
    clkEn && match0 && clearMode && !restart |=> cnt_q == `TCCU_CNT_ZERO)
    else $error("cycle match did not clear counter");
  a_out_toggle: assert property ( // R18
    clkEn && match0 && ctrl_q.outEn0 |=> ch0TimerOutput != $past(out0_q))
    else $error("output did not toggle on match");
  a_match_irq: assert property ( // R17
    clkEn && match0 |=> ch0MatchIrq)
    else $error("match request missing");
  a_trig_mode: assert property ( // R5
    triggerValid |-> $past(modeTrig))
    else $error("trigger accepted outside trigger modes");
  a_read_answer: assert property (
    readTaken && clkEn |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  c_overflow:  cover property (overflowIrq);
  c_capture0:  cover property (clkEn && cap0 && modeFree);
  c_width_cap: cover property (clkEn && widthClear);
  c_match_out: cover property (clkEn && match0 && ctrl_q.outEn0);
endmodule // tccu_top

// ---- testbench/tccu_pin_model.sv ----
`timescale 1ns/1ps
module tccu_pin_model
(
  input  wire logic clk_sys,
  input  wire logic tickOn,
  output logic      countTick,
  output logic      ch0Pin,
  output logic      ch1Pin
);
  initial
  begin
    countTick = 1'b0;
    ch0Pin    = 1'b0;
    ch1Pin    = 1'b0;
  end
  // Prescaler stand-in: a tick every cycle keeps the wrap test short
  always @(posedge clk_sys) countTick <= tickOn;
  // Each level is held long enough to pass the input synchroniser
  task automatic drive(input logic p0, input logic p1, input int hold);
    @(posedge clk_sys);
    ch0Pin <= p0;
    ch1Pin <= p1;
    repeat (hold) @(posedge clk_sys);
  endtask
endmodule // tccu_pin_model

// ---- testbench/tccu_top_tb.sv ----
`timescale 1ns/1ps
`include "tccu_defs.svh"
module tccu_top_tb;
  logic        clk_sys, rst, clkEn, tickOn, countTick, pin0, pin1;
  logic        ch0TimerOutput, overflowIrq, ch0MatchIrq, ch1MatchIrq;
  logic        triggerValid, outLast;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, e, c1, c2;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          nMismatch, nChecks, nMatch, nOvf, nTrig, nTog, nM1;
  int          i, a, b, c;
  // Event/trigger table: control, edge select, counter, trigger pulses
  logic [31:0] tCtrl [11] = '{32'h5, 32'h5, 32'h5, 32'h5, 32'h3, 32'h1,
                              32'h9, 32'h9, 32'hD, 32'h15, 32'h9};
  logic [31:0] tEdge [11] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h1, 32'h3,
                              32'h4, 32'h8, 32'hC, 32'hC, 32'h0};
  int          tCnt [11] = '{0, 2, 2, 4, 2, 0, 0, 0, 0, 0, 0};
  int          tTrg [11] = '{0, 0, 0, 0, 0, 0, 2, 2, 4, 0, 0};

  tccu_top i_tccu_top (.clk_sys, .rst, .clkEn, .countTick,
    .ch0SharedInput(pin0), .ch1CaptureInput(pin1), .ch0TimerOutput,
    .overflowIrq, .ch0MatchIrq, .ch1MatchIrq, .triggerValid,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  tccu_pin_model i_tccu_pin_model (.clk_sys, .tickOn, .countTick,
    .ch0Pin(pin0), .ch1Pin(pin1));

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Sampled mid-cycle so the counts never race the main sequence
  always @(negedge clk_sys)
  begin
    nMatch += (ch0MatchIrq === 1'b1);
    nOvf += (overflowIrq === 1'b1);
    nTrig += (triggerValid === 1'b1);
    nM1 += (ch1MatchIrq === 1'b1);
    if (ch0TimerOutput !== outLast) nTog++;
    outLast = ch0TimerOutput;
  end

  task automatic chk(input string n, input logic [31:0] x, logic [31:0] g);
    nChecks++;
    if (g !== x)
    begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chkLess(input string n, input logic [31:0] lo, hi);
    nChecks++;
    if ((hi > lo) !== 1'b1)
    begin
      nMismatch++;
      $display("MISMATCH %s expected above %h seen %h", n, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clk_sys);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt,
                    output logic [1:0] rs);
    @(posedge clk_sys);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    dt = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (80000) @(posedge clk_sys);
    nMismatch++;
    end_of_test;
  end

  initial
  begin
    {rst, clkEn, tickOn} = 3'h6;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (i = 0; i < 6; i++)
    begin
      rd(8'(4 * i), d, r);
      chk("reset value", 32'h0, d);
    end
    rd(8'h18, d, r);
    chk("unmapped response", `TCCU_RESP_SLVERR, 32'(r));
    wr(`TCCU_OFS_CH0_COMPARE_BUFFER, 32'hFFFF1234);
    rd(`TCCU_OFS_CH0_COMPARE_BUFFER, d, r);
    chk("channel 0 word", 32'h1234, d);
    wr(`TCCU_OFS_CCR1, 32'h0000ABCD);
    rd(`TCCU_OFS_CCR1, d, r);
    chk("channel 1 word", 32'hABCD, d);
    s_axi_wstrb <= 4'h1;
    wr(`TCCU_OFS_CCR1, 32'h00005555);
    s_axi_wstrb <= 4'hF;
    rd(`TCCU_OFS_CCR1, d, r);
    chk("channel 1 partial write", 32'hABCD, d);
    $display("test registers done");

    wr(`TCCU_OFS_CH0_COMPARE_BUFFER, 32'h4);
    wr(`TCCU_OFS_CCR1, 32'h2);
    wr(`TCCU_OFS_CTRL, 32'h21);
    tickOn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    {a, b, c} = {nMatch, nTog, nOvf};
    d = nM1;
    repeat (50) @(posedge clk_sys);
    chk("match pulses", 32'd10, nMatch - a);
    chk("channel 1 matches", 32'd10, nM1 - d);
    chk("output toggles", 32'd10, nTog - b);
    chk("overflow in interval", 32'd0, nOvf - c);
    // Rewrite while counting: period must follow the new value
    wr(`TCCU_OFS_CH0_COMPARE_BUFFER, 32'h9);
    repeat (20) @(posedge clk_sys);
    a = nMatch;
    repeat (50) @(posedge clk_sys);
    chk("match pulses rewritten", 32'd5, nMatch - a);
    // One edge in hand so a toggle launched before the freeze is counted
    clkEn <= 1'b0;
    @(posedge clk_sys);
    b = nTog;
    repeat (30) @(posedge clk_sys);
    chk("frozen output", 32'd0, nTog - b);
    clkEn <= 1'b1;
    wr(`TCCU_OFS_CTRL, 32'h0);
    wr(`TCCU_OFS_CH0_COMPARE_BUFFER, 32'h4);
    wr(`TCCU_OFS_CTRL, 32'h11);
    repeat (10) @(posedge clk_sys);
    a = nMatch;
    repeat (50) @(posedge clk_sys);
    chk("pwm match pulses", 32'd10, nMatch - a);
    $display("test interval done");

    tickOn <= 1'b0;
    wr(`TCCU_OFS_CH0_COMPARE_BUFFER, 32'h100);
    for (i = 0; i < 11; i++)
    begin
      wr(`TCCU_OFS_CTRL, 32'h0);
      wr(`TCCU_OFS_EDGE, tEdge[i]);
      wr(`TCCU_OFS_CTRL, tCtrl[i]);
      a = nTrig;
      repeat (2)
      begin
        i_tccu_pin_model.drive(1'b1, 1'b0, 6);
        i_tccu_pin_model.drive(1'b0, 1'b0, 6);
      end
      rd(`TCCU_OFS_COUNT, d, r);
      chk("event count", tCnt[i], d);
      chk("trigger pulses", tTrg[i], nTrig - a);
    end
    $display("test edges done");

    wr(`TCCU_OFS_CTRL, 32'h0);
    wr(`TCCU_OFS_EDGE, 32'h0);
    wr(`TCCU_OFS_OPTION, 32'h30);
    i_tccu_pin_model.drive(1'b0, 1'b1, 6);
    wr(`TCCU_OFS_CTRL, 32'h255);
    tickOn <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rd(`TCCU_OFS_COUNT, c1, r);
    i_tccu_pin_model.drive(1'b1, 1'b0, 12);
    rd(`TCCU_OFS_COUNT, c2, r);
    rd(`TCCU_OFS_CH0_COMPARE_BUFFER, d, r);
    rd(`TCCU_OFS_CCR1, e, r);
    chkLess("capture after start", c1, d);
    chkLess("capture before read", d, c2);
    chk("capture pair", d, e);
    $display("test free capture done");

    wr(`TCCU_OFS_CTRL, 32'h0);
    wr(`TCCU_OFS_OPTION, 32'h0);
    i_tccu_pin_model.drive(1'b0, 1'b0, 6);
    wr(`TCCU_OFS_CTRL, 32'h59);
    repeat (40) @(posedge clk_sys);
    i_tccu_pin_model.drive(1'b1, 1'b0, 6);
    rd(`TCCU_OFS_CH0_COMPARE_BUFFER, d, r);
    rd(`TCCU_OFS_COUNT, c2, r);
    chkLess("width capture", 32'd30, d);
    chkLess("counter cleared", c2, d);
    $display("test width done");

    wr(`TCCU_OFS_CTRL, 32'h0);
    wr(`TCCU_OFS_CTRL, 32'h15);
    c = nOvf;
    for (i = 0; i < 70000 && nOvf == c; i++) @(posedge clk_sys);
    chk("overflow pulses", 32'd1, nOvf - c);
    chkLess("wrap span", 32'd65500, i);
    rd(`TCCU_OFS_OPTION, d, r);
    chk("flag set", 32'h1, d);
    wr(`TCCU_OFS_OPTION, 32'h1);
    rd(`TCCU_OFS_OPTION, d, r);
    chk("flag after read and write 1", 32'h1, d);
    wr(`TCCU_OFS_OPTION, 32'h0);
    rd(`TCCU_OFS_OPTION, d, r);
    chk("flag after write 0", 32'h0, d);
    $display("test overflow done");
    end_of_test;
  end
endmodule // tccu_top_tb
